//--- logic/tsi_consts.vh
`ifndef TSI_CONSTS_VH
`define TSI_CONSTS_VH
// Fixed upper six bits of the target address
`define TSI_ADDR_FIXED 6'h10
// Bit positions inside the address byte
`define TSI_ADDR_SEL_BIT 1
`define TSI_RW_BIT 0
// Bits per byte before the acknowledge clock
`define TSI_BITS_PER_BYTE 4'h8
// Byte engine states
`define TSI_ST_IDLE 3'h0
`define TSI_ST_ADDR 3'h1
`define TSI_ST_AACK 3'h2
`define TSI_ST_RX 3'h3
`define TSI_ST_RACK 3'h4
`define TSI_ST_TX 3'h5
`define TSI_ST_TACK 3'h6
// System clock rate
`define TSI_SYS_CLK_MHZ 100
// Least hold of the bus-signalled START before its STOP
`define TSI_BUS_INT_HOLD_NS 600
// Least bus-free time before a bus-signalled interrupt
`define TSI_BUS_FREE_NS 1300
// Half period of the internal sample clock, in system clocks
`define TSI_SAMPLE_HALF_DIV 64
`endif

//--- logic/tsi_target.v
`timescale 1ns/10ps
// Notes on behaviour
// - SDA only pulled low, else released
// - One bit per SCL pulse, stable high
// - START is SDA fall with SCL high
// - STOP is SDA rise with SCL high
// - Eight bits then one acknowledge clock
// - Acknowledge every received byte when addressed
// - Release SDA after master withholds acknowledge
// - Match fixed 010000 plus select bit
// - Address bit 1 equals select pin level
// - Address LSB chooses write or read
// - Address, command byte, then data bytes
// - Read without command returns sensor state
// - Keep resending sensor state until STOP
// - Leader byte first, follower byte next
// - Leader and follower alternate until STOP
// - Follower answers leader address for direct read
// - Leader drives sample clock, follower uses input
// - Leader samples rising, follower falling edge
// - Follower interrupt ORs own and leader's
// - Follower alone may signal over the bus; the code lets any mode signal when int_over_bus_en is set
// - Sensor state holds eight channel bits
// - Reading sensor state clears pending interrupt
// - Bus interrupt is START then STOP
`include "tsi_consts.vh"
module tsi_target #(
  parameter DATA_W = 8,
  parameter SAMPLE_HALF_DIV = `TSI_SAMPLE_HALF_DIV
) (
  input wire sys_clk,
  input wire reset,
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output reg sda_oe_n,
  output wire scl_out,
  output wire scl_oe_n,
  input wire address_select_pin,
  input wire leader_mode,
  input wire follower_mode,
  input wire int_over_bus_en,
  input wire [7:0] channel_state_bits,
  input wire sensor_event,
  input wire cascade_int_n,
  input wire clk_in,
  output reg clk_out,
  output reg sample_strobe,
  output reg int_n,
  output wire rx_valid,
  input wire rx_ready,
  output wire [DATA_W-1:0] rx_data,
  output wire rx_is_command
);
  // Cycle counts derived from nanosecond figures, least times rounded up
  localparam integer HOLD_CYC =
    (`TSI_BUS_INT_HOLD_NS * `TSI_SYS_CLK_MHZ + 999) / 1000;
  localparam integer FREE_CYC =
    (`TSI_BUS_FREE_NS * `TSI_SYS_CLK_MHZ + 999) / 1000;
  localparam [7:0] HOLD_CNT = HOLD_CYC[7:0];
  localparam [7:0] FREE_CNT = FREE_CYC[7:0];
  localparam integer HALF_CYC = SAMPLE_HALF_DIV - 1;
  localparam [15:0] HALF_CNT = HALF_CYC[15:0];

  // Two-flop synchronisers for every pin input
  reg [1:0] scl_sync;
  reg [1:0] sda_sync;
  reg [1:0] sel_sync;
  reg [1:0] cint_sync;
  reg [1:0] clki_sync;
  reg scl_d; // Previous synchronised SCL
  reg sda_d; // Previous synchronised SDA
  reg clki_d; // Previous synchronised clock input

  always @(posedge sys_clk) begin
    if (reset) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      sel_sync <= 2'h0;
      cint_sync <= 2'h3;
      clki_sync <= 2'h0;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      clki_d <= 1'b0;
    end else begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      sel_sync <= {sel_sync[0], address_select_pin};
      cint_sync <= {cint_sync[0], cascade_int_n};
      clki_sync <= {clki_sync[0], clk_in};
      scl_d <= scl_sync[1];
      sda_d <= sda_sync[1];
      clki_d <= clki_sync[1];
    end
  end

  wire scl_s = scl_sync[1];
  wire sda_s = sda_sync[1];
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_det = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_det = scl_s & scl_d & ~sda_d & sda_s;
  wire cascade = leader_mode | follower_mode;

  // Byte engine registers
  reg [2:0] state;
  reg [3:0] bit_cnt;
  reg [7:0] shreg;
  reg rw_read; // Direction taken from the address byte
  reg casc_rd; // Alternating cascaded direct read in progress
  reg tx_drive; // This chip owns the current read byte
  reg first_rx; // Next received byte is the command
  reg push_pend; // Received byte waiting for buffer room
  reg master_nack; // Master withheld acknowledge
  reg int_pending; // Own interrupt, cleared by a state read

  // Address decode; follower also takes the leader address for a read
  wire addr_fixed_ok = shreg[7:2] == `TSI_ADDR_FIXED;
  wire addr_own = addr_fixed_ok & (shreg[1] == sel_sync[1]);
  wire addr_casc = addr_fixed_ok & cascade & ~shreg[1] & shreg[0];
  wire byte_done = scl_fall & (bit_cnt == `TSI_BITS_PER_BYTE);
  // Owner of the next read byte: leader first, then alternate
  wire next_drive = (state == `TSI_ST_AACK) ?
    ~(casc_rd & follower_mode) : (casc_rd ? ~tx_drive : 1'b1);

  // Two-entry receive buffer between the bus and the user side
  reg [DATA_W:0] buf_mem [0:1];
  reg buf_wp;
  reg buf_rp;
  reg [1:0] buf_cnt;
  wire buf_in_ready = buf_cnt != 2'h2;
  wire buf_push = (state == `TSI_ST_RACK) & push_pend & buf_in_ready;
  wire buf_pop = rx_valid & rx_ready;
  assign rx_valid = buf_cnt != 2'h0;
  assign rx_data = buf_mem[buf_rp][DATA_W-1:0];
  assign rx_is_command = buf_mem[buf_rp][DATA_W];

  // Buffer pointers and storage
  always @(posedge sys_clk) begin
    if (reset) begin
      buf_wp <= 1'b0;
      buf_rp <= 1'b0;
      buf_cnt <= 2'h0;
    end else begin
      if (buf_push) begin
        buf_mem[buf_wp] <= {first_rx, shreg[DATA_W-1:0]};
        buf_wp <= ~buf_wp;
      end
      if (buf_pop)
        buf_rp <= ~buf_rp;
      if (buf_push & ~buf_pop)
        buf_cnt <= buf_cnt + 2'h1;
      else if (buf_pop & ~buf_push)
        buf_cnt <= buf_cnt - 2'h1;
    end
  end

  // Hold SCL low while a received byte cannot enter the full buffer
  assign scl_out = 1'b0;
  assign scl_oe_n = ~((state == `TSI_ST_RACK) & push_pend & ~buf_in_ready);
  assign sda_out = 1'b0;

  // Bus-signalled interrupt sequencer
  reg bus_int_req;
  reg bi_active;
  reg [7:0] bi_cnt;
  reg [7:0] free_cnt;
  wire bus_free = (free_cnt == FREE_CNT) & (state == `TSI_ST_IDLE);

  // Main byte engine; START and STOP take priority everywhere
  always @(posedge sys_clk) begin
    if (reset) begin
      state <= `TSI_ST_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      rw_read <= 1'b0;
      casc_rd <= 1'b0;
      tx_drive <= 1'b0;
      first_rx <= 1'b0;
      push_pend <= 1'b0;
      master_nack <= 1'b0;
    end else if (start_det) begin
      state <= `TSI_ST_ADDR; // Repeated START restarts the access
      bit_cnt <= 4'h0;
    end else if (stop_det) begin
      state <= `TSI_ST_IDLE;
    end else begin
      case (state)
        `TSI_ST_ADDR: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], sda_s}; // Sample while SCL high
            bit_cnt <= bit_cnt + 4'h1;
          end
          if (byte_done) begin
            bit_cnt <= 4'h0;
            rw_read <= shreg[`TSI_RW_BIT];
            casc_rd <= addr_casc;
            first_rx <= 1'b1;
            // Unmatched address is left unacknowledged
            if (addr_own | (follower_mode & addr_casc))
              state <= `TSI_ST_AACK;
            else
              state <= `TSI_ST_IDLE;
          end
        end
        `TSI_ST_AACK: begin
          if (scl_fall) begin
            if (rw_read) begin
              // Direct read loads sensor state at once
              shreg <= channel_state_bits;
              tx_drive <= next_drive;
              state <= `TSI_ST_TX;
            end else begin
              state <= `TSI_ST_RX;
            end
          end
        end
        `TSI_ST_RX: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end
          if (byte_done) begin
            bit_cnt <= 4'h0;
            push_pend <= 1'b1;
            state <= `TSI_ST_RACK;
          end
        end
        `TSI_ST_RACK: begin
          if (buf_push) begin
            push_pend <= 1'b0;
            first_rx <= 1'b0; // Later bytes are data
          end
          if (scl_fall)
            state <= `TSI_ST_RX;
        end
        `TSI_ST_TX: begin
          if (scl_rise)
            bit_cnt <= bit_cnt + 4'h1;
          if (scl_fall & (bit_cnt != `TSI_BITS_PER_BYTE))
            shreg <= {shreg[6:0], 1'b0};
          if (byte_done) begin
            bit_cnt <= 4'h0;
            state <= `TSI_ST_TACK;
          end
        end
        `TSI_ST_TACK: begin
          if (scl_rise)
            master_nack <= sda_s;
          if (scl_fall) begin
            if (master_nack) begin
              state <= `TSI_ST_IDLE; // Line stays released
            end else begin
              shreg <= channel_state_bits; // Resend current state
              tx_drive <= next_drive;
              state <= `TSI_ST_TX;
            end
          end
        end
        default: begin
          bit_cnt <= 4'h0;
          push_pend <= 1'b0;
        end
      endcase
    end
  end

  // SDA drive: acks, owned read bits and the bus interrupt pulse
  always @(posedge sys_clk) begin
    if (reset)
      sda_oe_n <= 1'b1;
    else if (bi_active)
      sda_oe_n <= 1'b0;
    else if ((state == `TSI_ST_AACK) | (state == `TSI_ST_RACK))
      sda_oe_n <= 1'b0; // Held through the ack high phase
    else if ((state == `TSI_ST_TX) & tx_drive)
      sda_oe_n <= shreg[7]; // Last bit held through its high phase
    else
      sda_oe_n <= 1'b1;
  end

  // Interrupt pending: a new event wins over a clearing read
  wire state_read = scl_fall & rw_read & next_drive &
    (((state == `TSI_ST_TACK) & ~master_nack) | (state == `TSI_ST_AACK));
  always @(posedge sys_clk) begin
    if (reset) begin
      int_pending <= 1'b0;
      int_n <= 1'b1;
    end else begin
      if (sensor_event)
        int_pending <= 1'b1;
      else if (state_read)
        int_pending <= 1'b0;
      // Follower merges the leader interrupt from the cascade input
      int_n <= ~(int_pending | (follower_mode & ~cint_sync[1]));
    end
  end

  // Bus interrupt: follower also relays the leader's interrupt
  wire bus_event = sensor_event | (follower_mode & ~cint_sync[1] & ~int_n);
  always @(posedge sys_clk) begin
    if (reset) begin
      bus_int_req <= 1'b0;
      bi_active <= 1'b0;
      bi_cnt <= 8'h00;
      free_cnt <= 8'h00;
    end else begin
      // Count idle time with both lines high
      if (~(scl_s & sda_s) | bi_active)
        free_cnt <= 8'h00;
      else if (free_cnt != FREE_CNT)
        free_cnt <= free_cnt + 8'h01;
      if (int_over_bus_en & bus_event & ~bus_int_req)
        bus_int_req <= 1'b1;
      else if (bi_active & (bi_cnt == HOLD_CNT))
        bus_int_req <= 1'b0;
      // Pull SDA low (START), hold, then release (STOP)
      if (bus_int_req & bus_free & ~bi_active) begin
        bi_active <= 1'b1;
        bi_cnt <= 8'h00;
      end else if (bi_active) begin
        if (bi_cnt == HOLD_CNT)
          bi_active <= 1'b0;
        else
          bi_cnt <= bi_cnt + 8'h01;
      end
    end
  end

  // Sample clock: leader divides and drives it, follower follows input
  reg [15:0] div_cnt;
  reg int_clk;
  always @(posedge sys_clk) begin
    if (reset) begin
      div_cnt <= 16'h0000;
      int_clk <= 1'b0;
      clk_out <= 1'b0;
      sample_strobe <= 1'b0;
    end else begin
      if (div_cnt == HALF_CNT) begin
        div_cnt <= 16'h0000;
        int_clk <= ~int_clk;
      end else begin
        div_cnt <= div_cnt + 16'h0001;
      end
      clk_out <= leader_mode & int_clk;
      if (follower_mode)
        sample_strobe <= ~clki_sync[1] & clki_d; // Inverted input
      else
        sample_strobe <= (div_cnt == HALF_CNT) & ~int_clk;
    end
  end
endmodule

//--- tb/tsi_target_assertions.sv
`timescale 1ns/10ps
// Port-level checks on the touch sensor bus target
module tsi_target_assertions #(
  parameter DATA_W = 8,
  parameter SAMPLE_HALF_DIV = 64
) (
  input wire sys_clk,
  input wire reset,
  input wire scl_in,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe_n,
  input wire scl_out,
  input wire scl_oe_n,
  input wire address_select_pin,
  input wire leader_mode,
  input wire follower_mode,
  input wire int_over_bus_en,
  input wire [7:0] channel_state_bits,
  input wire sensor_event,
  input wire cascade_int_n,
  input wire clk_in,
  input wire clk_out,
  input wire sample_strobe,
  input wire int_n,
  input wire rx_valid,
  input wire rx_ready,
  input wire [DATA_W-1:0] rx_data,
  input wire rx_is_command
);
  // Leader strobe spacing in system clocks
  localparam int GAP = 2 * SAMPLE_HALF_DIV;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  chk_sda_low_only: assert property (sda_out == 1'b0)
    else $error("sda output drives high");
  chk_scl_low_only: assert property (scl_out == 1'b0)
    else $error("scl output drives high");
  chk_reset_quiet: assert property (disable iff (1'b0)
    reset |=> sda_oe_n && int_n && !clk_out) else $error("outputs active after reset");
  // Bus-signalled interrupt moves sda with scl high on purpose, so it is excluded
  chk_sda_steady_high: assert property (!int_over_bus_en && scl_in && $past(scl_in)
    |-> $stable(sda_oe_n)) else $error("sda moved while scl high");
  chk_clk_out_role: assert property (!leader_mode |=> !clk_out)
    else $error("sample clock out while not leader");
  chk_strobe_pulse: assert property (sample_strobe |=> !sample_strobe)
    else $error("sample strobe longer than one cycle");
  chk_leader_rate: assert property (leader_mode && !follower_mode && sample_strobe
    |-> ##GAP (sample_strobe || !leader_mode)) else $error("leader strobe spacing");
  chk_follower_edge: assert property (follower_mode && $fell(clk_in)
    |-> ##[1:5] sample_strobe) else $error("follower missed clock fall");
  chk_cascade_or: assert property ((follower_mode && !cascade_int_n) [*4]
    |=> !int_n) else $error("leader interrupt not passed on");
  chk_event_raises: assert property (sensor_event |-> ##[1:3] !int_n)
    else $error("event did not raise interrupt");
  chk_rx_head_hold: assert property (rx_valid && !rx_ready
    |=> rx_valid && $stable(rx_data) && $stable(rx_is_command))
    else $error("buffer head changed unread");
  chk_stretch_full: assert property (!scl_oe_n |-> rx_valid)
    else $error("clock held with empty buffer");
endmodule

bind tsi_target tsi_target_assertions #(.DATA_W(DATA_W), .SAMPLE_HALF_DIV(SAMPLE_HALF_DIV)) chk_u (
  .sys_clk(sys_clk), .reset(reset), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
  .address_select_pin(address_select_pin), .leader_mode(leader_mode),
  .follower_mode(follower_mode), .int_over_bus_en(int_over_bus_en),
  .channel_state_bits(channel_state_bits), .sensor_event(sensor_event),
  .cascade_int_n(cascade_int_n), .clk_in(clk_in), .clk_out(clk_out),
  .sample_strobe(sample_strobe), .int_n(int_n), .rx_valid(rx_valid), .rx_ready(rx_ready),
  .rx_data(rx_data), .rx_is_command(rx_is_command)
);

//--- tb/tsi_i2c_master.sv
`timescale 1ns/10ps
// Bus master model; lines are released (1) or pulled low (0)
module tsi_i2c_master (
  input wire sys_clk,
  input wire scl,
  input wire sda,
  output reg scl_drv,
  output reg sda_drv
);
  int stuck = 0; // Stretch waits that ran out
  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Data moves only with scl low, sampled at end of high
  task automatic bit_io(input logic b, output logic r);
    int n;
    n = 0;
    wt(2);
    sda_drv <= b;
    wt(8);
    scl_drv <= 1'b1;
    // Target may stretch the low phase, so wait for the wire itself
    while (scl !== 1'b1 && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 3000) stuck++;
    wt(8);
    r = sda;
    scl_drv <= 1'b0;
  endtask
  // Start or repeated start, entered with scl low or idle
  task automatic start();
    wt(2);
    sda_drv <= 1'b1;
    wt(8);
    scl_drv <= 1'b1;
    wt(8);
    sda_drv <= 1'b0;
    wt(8);
    scl_drv <= 1'b0;
  endtask
  task automatic stop();
    wt(2);
    sda_drv <= 1'b0;
    wt(8);
    scl_drv <= 1'b1;
    wt(8);
    sda_drv <= 1'b1;
    wt(8);
  endtask
  // Eight bits MSB first, then the acknowledge clock
  task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q, output logic ao);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ai, ao);
  endtask
endmodule

//--- tb/tsi_target_tb_top.sv
`timescale 1ns/10ps
module tsi_target_tb_top;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic address_select_pin = 1'b0, leader_mode = 1'b0, follower_mode = 1'b0;
  logic int_over_bus_en = 1'b0, sensor_event = 1'b0, cascade_int_n = 1'b1, clk_in = 1'b0;
  logic rx_ready = 1'b0, hold = 1'b1, stretched = 1'b0, a;
  logic [7:0] chan = 8'h00, q, d;
  wire scl_drv, sda_drv, sda_out, sda_oe_n, scl_out, scl_oe_n, clk_out, sample_strobe;
  wire int_n, rx_valid, rx_is_command;
  wire [7:0] rx_data;
  // Wired-AND of all open-drain drivers, pull-up when released
  wire scl = scl_drv & (scl_oe_n | scl_out);
  wire sda = sda_drv & (sda_oe_n | sda_out);
  logic [8:0] expq[$]; // Bytes due at the buffer output, command flag on top
  int failures = 0, checked = 0, cyc = 0, n, n2;
  tsi_target #(.DATA_W(8), .SAMPLE_HALF_DIV(2)) dut_u (
    .sys_clk(sys_clk), .reset(reset), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
    .address_select_pin(address_select_pin), .leader_mode(leader_mode),
    .follower_mode(follower_mode), .int_over_bus_en(int_over_bus_en),
    .channel_state_bits(chan), .sensor_event(sensor_event), .cascade_int_n(cascade_int_n),
    .clk_in(clk_in), .clk_out(clk_out), .sample_strobe(sample_strobe), .int_n(int_n),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .rx_is_command(rx_is_command)
  );
  tsi_i2c_master m_u (.sys_clk(sys_clk), .scl(scl), .sda(sda), .scl_drv(scl_drv), .sda_drv(sda_drv));
  always #5 sys_clk = ~sys_clk;
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Random receiver stalls, a slow cascade clock and the hang limit
  always @(posedge sys_clk) begin
    rx_ready <= !hold && $urandom_range(1, 0);
    cyc <= cyc + 1;
    if (cyc % 7 == 6) clk_in <= !clk_in;
    if (cyc == 40000) begin
      failures++;
      give_verdict();
    end
  end
  // Compares each popped byte with the oldest note
  always @(posedge sys_clk) begin
    if (!scl_oe_n) stretched <= 1'b1;
    if (!reset && rx_valid === 1'b1 && rx_ready) begin
      if (expq.size() == 0) check("spare byte", {rx_is_command, rx_data}, 9'h1FF);
      else check("rx byte", {rx_is_command, rx_data}, expq.pop_front());
    end
  end
  task automatic wr(input logic [7:0] v, input logic ack);
    m_u.xfer(v, 1'b1, q, a);
    check("ack bit", {8'h00, a}, {8'h00, !ack});
  endtask
  task automatic addr(input logic s, input logic rw, input logic ack);
    m_u.start();
    wr({6'h10, s, rw}, ack);
  endtask
  // Master acks all but the last byte, even and odd bytes may differ
  task automatic rd(input int k, input logic [7:0] e0, input logic [7:0] e1);
    for (int i = 0; i < k; i++) begin
      m_u.xfer(8'hFF, i == k - 1, q, a);
      check("read byte", {1'b0, q}, {1'b0, (i % 2) ? e1 : e0});
    end
  endtask
  initial begin
    void'($urandom(32'h21b55ab4));
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    address_select_pin <= $urandom_range(1, 0);
    repeat (6) @(posedge sys_clk);
    // Command then data; receiver stalls first so the buffer fills
    fork
      begin
        repeat (1500) @(posedge sys_clk);
        hold <= 1'b0;
      end
    join_none
    addr(address_select_pin, 1'b0, 1'b1);
    for (int i = 0; i < 5; i++) begin
      d = $urandom;
      expq.push_back({i == 0, d});
      wr(d, 1'b1);
    end
    m_u.stop();
    repeat (60) @(posedge sys_clk);
    check("stretch", {8'h00, stretched}, 9'h001);
    check("left bytes", expq.size(), 9'h000);
    $display("write test done");
    addr(!address_select_pin, 1'b0, 1'b0);
    m_u.stop();
    m_u.start();
    wr({6'h11, address_select_pin, 1'b0}, 1'b0);
    m_u.stop();
    $display("address test done");
    // Bus signalling is armed in the same cycle as the event, since the request is taken from the pulse
    int_over_bus_en <= 1'b1;
    sensor_event <= 1'b1;
    @(posedge sys_clk);
    sensor_event <= 1'b0;
    repeat (4) @(posedge sys_clk);
    check("int pending", {8'h00, int_n}, 9'h000);
    n = 0;
    while (sda_oe_n !== 1'b0 && n < 400) begin
      @(posedge sys_clk);
      n++;
    end
    n = 0;
    while (sda_oe_n === 1'b0 && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
    int_over_bus_en <= 1'b0;
    check("bus int hold", n[8:0], 9'h03D);
    chan <= $urandom;
    addr(address_select_pin, 1'b1, 1'b1);
    rd(3, chan, chan);
    repeat (6) @(posedge sys_clk);
    check("released", {8'h00, sda_oe_n}, 9'h001);
    m_u.stop();
    check("int cleared", {8'h00, int_n}, 9'h001);
    $display("read test done");
    leader_mode <= 1'b1;
    repeat (8) @(posedge sys_clk);
    n = 0;
    n2 = 0;
    repeat (40) begin
      @(posedge sys_clk);
      n += sample_strobe;
      n2 += clk_out;
    end
    check("strobes", n[8:0], 9'h00A);
    check("clk out high", n2[8:0], 9'h014);
    leader_mode <= 1'b0;
    follower_mode <= 1'b1;
    cascade_int_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    check("cascade int", {8'h00, int_n}, 9'h000);
    cascade_int_n <= 1'b1;
    address_select_pin <= 1'b1;
    chan <= $urandom;
    addr(1'b0, 1'b1, 1'b1);
    rd(4, 8'hFF, chan);
    m_u.stop();
    // Follower on its own address sends every byte itself
    addr(1'b1, 1'b1, 1'b1);
    rd(2, chan, chan);
    m_u.stop();
    check("stuck", m_u.stuck[8:0], 9'h000);
    $display("cascade test done");
    give_verdict();
  end
endmodule
